// ==== hw/rmle_top.sv ====
// Purpose: Media eject, lock and unlock command handling behind APB
// Assumes: 40 MHz pclk, asynchronous active-low presetn, APB slave
// Notes: Pins are synchronised before use
//
// Overview of operation
// - Decode EDh eject, DEh lock, DFh unlock
// - Media commands have no data phase
// - Good completion: BSY0 DRDY1 DF0 DRQ0 ERR0 (code copies the fault pin into DF even when ERR is 0)
// - Unsupported media command ends with ABRT
// - ABRT allowed when action cannot be done
// - No medium sets NM at completion
// - Error completion sets DRDY, DF, ERR properly
// - DEV bit kept through command and completion
// - Eject: finish ops, spin down, unlock, eject
// - Notification enabled: lock does nothing, good
// - Present and unlocked: lock sets LOCKED
// - Only one lock level is kept
// - Lock while locked with request sets MCR
// - Button while locked and idle sets MCR and ERR
// - Unlock with medium present fully unlocks
// - Pending change request ejects at unlock
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module rmle_top
	import rmle_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        media_present_pin,
	input  wire logic        change_button_pin,
	input  wire logic        dev_fault_pin,
	input  wire logic        ops_idle_pin,
	input  wire logic        spun_down_pin,
	output logic             spin_down_req,
	output logic             eject_req,
	output logic             irq
);
	typedef struct packed {
		rmle_state_type st;
		logic [7:0]     op;
		logic [7:0]     dev_head;
		logic [7:0]     status;
		logic [7:0]     error;
		logic [3:0]     ctrl;
		logic           locked;
		logic           mcr_pend;
		logic           btn_d;
		logic [2:0]     irq_sts;
		logic [2:0]     irq_msk;
		logic           irq;
		logic           eject;
		logic           spin;
		logic [31:0]    prdata;
		logic           pready;
		logic           pslverr;
	} rmle_regs_type;

	rmle_pin_if pins ();

	rmle_sync u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.raw     ({spun_down_pin, ops_idle_pin, dev_fault_pin, change_button_pin,
			media_present_pin}),
		.pins    (pins.src)
	);

	rmle_regs_type r;
	rmle_regs_type n;
	logic          press;
	logic          acc;
	logic          cmd_take;

	assign press    = pins.button & ~r.btn_d;
	assign acc      = psel & penable & r.pready;
	assign cmd_take = acc & pwrite & (paddr == OFS_CMD) & r.status[ST_DRDY]
		& ~r.status[ST_BSY];

	always_comb begin
		logic       done;
		logic [7:0] errv;
		logic [2:0] set;
		logic [2:0] clr;
		done    = 1'b0;
		errv    = ERROR_RST;
		set     = 3'b000;
		clr     = 3'b000;
		n       = r;
		n.eject = 1'b0;
		n.btn_d = pins.button;
		// APB answer loaded at setup, shown in the access cycle
		n.pready  = psel & ~penable;
		n.pslverr = 1'b0;
		if (psel && !penable) begin
			n.prdata = RD_ZERO;
			case (paddr)
				OFS_CMD: begin
				end
				OFS_DEVH: n.prdata[7:0] = r.dev_head;
				OFS_STAT: n.prdata[7:0] = r.status;
				OFS_ERR: n.prdata[7:0] = r.error;
				OFS_CTRL: n.prdata[3:0] = r.ctrl;
				OFS_MEDIA: n.prdata[3:0] = {r.spin, r.mcr_pend, r.locked, pins.present};
				OFS_IRQS: n.prdata[2:0] = r.irq_sts;
				OFS_IRQM: n.prdata[2:0] = r.irq_msk;
				default: n.pslverr = 1'b1;
			endcase
		end
		if (acc && pwrite) begin
			case (paddr)
				OFS_DEVH: begin
					if (!r.status[ST_BSY]) begin
						n.dev_head = pwdata[7:0];
					end
				end
				OFS_CTRL: n.ctrl = pwdata[3:0];
				OFS_IRQM: n.irq_msk = pwdata[2:0];
				default: begin
				end
			endcase
		end
		// Only accepted while ready and not busy
		if (cmd_take) begin
			n.op     = pwdata[7:0];
			n.st     = ST_EXEC;
			n.status = STATUS_BUSY;
			n.error  = ERROR_RST;
		end
		// Read clears only the bits that were returned
		if (acc && !pwrite && paddr == OFS_IRQS) begin
			clr = r.prdata[2:0];
		end
		case (r.st)
			ST_IDLE: begin
			end
			ST_EXEC: begin
				done = 1'b1;
				case (r.op)
					OP_EJECT: begin
						if (!r.ctrl[CT_EJ]) begin
							errv[ER_ABRT] = 1'b1;
						end else if (!pins.present) begin
							errv[ER_NM] = 1'b1;
						end else begin
							done = 1'b0;
							n.st = ST_OPS;
						end
					end
					OP_LOCK: begin
						if (!r.ctrl[CT_LK]) begin
							errv[ER_ABRT] = 1'b1;
						end else if (r.ctrl[CT_NOTIFY]) begin
							errv = ERROR_RST;
						end else if (!pins.present) begin
							errv[ER_NM] = 1'b1;
						end else if (r.locked) begin
							errv[ER_MCR] = r.mcr_pend;
						end else begin
							n.locked = 1'b1;
						end
					end
					OP_UNLOCK: begin
						if (!r.ctrl[CT_UL]) begin
							errv[ER_ABRT] = 1'b1;
						end else if (r.ctrl[CT_NOTIFY]) begin
							errv = ERROR_RST;
						end else if (!pins.present) begin
							errv[ER_NM] = 1'b1;
						end else begin
							n.locked   = 1'b0;
							n.mcr_pend = 1'b0;
							if (r.mcr_pend) begin
								n.eject     = 1'b1;
								set[IQ_EJ] = 1'b1;
							end
						end
					end
					default: errv[ER_ABRT] = 1'b1;
				endcase
			end
			ST_OPS: begin
				if (pins.ops_idle) begin
					n.st   = ST_SPIN;
					n.spin = 1'b1;
				end
			end
			ST_SPIN: begin
				if (pins.spun_down) begin
					n.st   = ST_EJECT;
					n.spin = 1'b0;
				end
			end
			ST_EJECT: begin
				n.locked    = 1'b0;
				n.mcr_pend  = 1'b0;
				n.eject     = 1'b1;
				set[IQ_EJ] = 1'b1;
				done        = 1'b1;
			end
			default: n.st = ST_IDLE;
		endcase
		if (done) begin
			n.st               = ST_IDLE;
			n.error            = errv;
			n.status           = STATUS_RST;
			n.status[ST_DF]    = pins.fault;
			n.status[ST_ERR]   = |errv;
			set[IQ_DONE]       = 1'b1;
		end
		// Change request button while locked
		if (press && n.locked) begin
			n.mcr_pend  = 1'b1;
			set[IQ_BTN] = 1'b1;
			if (n.st == ST_IDLE) begin
				n.error[ER_MCR]  = 1'b1;
				n.status[ST_ERR] = 1'b1;
			end
		end
		n.irq_sts = (r.irq_sts & ~clr) | set;
		n.irq     = |(n.irq_sts & n.irq_msk);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r          <= '0;
			r.st       <= ST_IDLE;
			r.status   <= STATUS_RST;
			r.error    <= ERROR_RST;
			r.dev_head <= DEVH_RST;
			r.ctrl     <= CTRL_RST;
			r.irq_msk  <= IRQM_RST;
		end else begin
			r <= n;
		end
	end

	assign prdata        = r.prdata;
	assign pready        = r.pready;
	assign pslverr       = r.pslverr;
	assign spin_down_req = r.spin;
	assign eject_req     = r.eject;
	assign irq           = r.irq;

	// Checks
	logic ex_ok;
	logic ex_lk;
	logic ex_ul;
	assign ex_ok = r.st == ST_EXEC && pins.present && !r.ctrl[CT_NOTIFY];
	assign ex_lk = ex_ok && r.op == OP_LOCK && r.ctrl[CT_LK];
	assign ex_ul = ex_ok && r.op == OP_UNLOCK && r.ctrl[CT_UL];

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	cmd_take_a: assert property (cmd_take |=> r.status[ST_BSY] && r.st == ST_EXEC)
		else $error("command not taken");
	no_drq_a: assert property (!r.status[ST_DRQ])
		else $error("data request raised");
	good_done_a: assert property (ex_lk && !r.locked |=> r.status == STATUS_RST
		&& r.error == ERROR_RST)
		else $error("good completion status wrong");
	bad_op_a: assert property (r.st == ST_EXEC && r.op != OP_EJECT && r.op != OP_LOCK
		&& r.op != OP_UNLOCK |=> r.error[ER_ABRT] && r.status[ST_ERR])
		else $error("unknown command not aborted");
	no_media_a: assert property (r.st == ST_EXEC && r.op == OP_EJECT && r.ctrl[CT_EJ]
		&& !pins.present |=> r.error[ER_NM] && !r.eject)
		else $error("missing medium not reported");
	err_sum_a: assert property (!r.status[ST_BSY] |-> r.status[ST_ERR] == |r.error
		&& r.status[ST_DRDY])
		else $error("error summary mismatch");
	dev_hold_a: assert property (r.status[ST_BSY] |=> $stable(r.dev_head))
		else $error("device select changed while busy");
	eject_seq_a: assert property (r.st == ST_SPIN && pins.spun_down |=> r.st == ST_EJECT
		##1 r.eject && !r.locked && !r.status[ST_BSY])
		else $error("eject sequence broken");
	notify_a: assert property (r.st == ST_EXEC && r.op == OP_LOCK && r.ctrl[CT_LK]
		&& r.ctrl[CT_NOTIFY] |=> !r.status[ST_ERR] && $stable(r.locked))
		else $error("lock acted under notification");
	lock_mcr_a: assert property (ex_lk && r.locked |=> r.locked
		&& r.error[ER_MCR] == $past(r.mcr_pend))
		else $error("lock while locked wrong");
	button_a: assert property (press && r.locked && r.st == ST_IDLE && !cmd_take
		|=> r.mcr_pend && r.error[ER_MCR] && r.status[ST_ERR])
		else $error("button while locked ignored");
	unlock_a: assert property (ex_ul |=> !r.locked
		&& r.eject == $past(r.mcr_pend))
		else $error("unlock did not release or eject");

	eject_c: cover property (r.st == ST_EJECT ##1 r.eject);
	lock_c: cover property (ex_lk && !r.locked ##1 r.locked);
	mcr_c: cover property (ex_lk && r.mcr_pend);
	unl_ej_c: cover property (ex_ul && r.mcr_pend);
endmodule : rmle_top
`default_nettype wire

// ==== hw/rmle_pkg.sv ====
// Purpose: Shared constants and types for the media lock and eject block
// Assumes: APB register map with 32-bit aligned words
// Notes: Status and error layouts follow the task-file bit positions
package rmle_pkg;
	// Command codes
	localparam logic [7:0] OP_EJECT  = 8'hED;
	localparam logic [7:0] OP_LOCK   = 8'hDE;
	localparam logic [7:0] OP_UNLOCK = 8'hDF;
	// Register byte offsets
	localparam logic [7:0] OFS_CMD   = 8'h00;
	localparam logic [7:0] OFS_DEVH  = 8'h04;
	localparam logic [7:0] OFS_STAT  = 8'h08;
	localparam logic [7:0] OFS_ERR   = 8'h0C;
	localparam logic [7:0] OFS_CTRL  = 8'h10;
	localparam logic [7:0] OFS_MEDIA = 8'h14;
	localparam logic [7:0] OFS_IRQS  = 8'h18;
	localparam logic [7:0] OFS_IRQM  = 8'h1C;
	// Completion state bits
	localparam int ST_BSY  = 7;
	localparam int ST_DRDY = 6;
	localparam int ST_DF   = 5;
	localparam int ST_DRQ  = 3;
	localparam int ST_ERR  = 0;
	// Error flag bits
	localparam int ER_MCR  = 3;
	localparam int ER_ABRT = 2;
	localparam int ER_NM   = 1;
	// Device select bit
	localparam int DH_DEV  = 4;
	// Control bits
	localparam int CT_NOTIFY = 0;
	localparam int CT_EJ     = 1;
	localparam int CT_LK     = 2;
	localparam int CT_UL     = 3;
	// Interrupt bits
	localparam int IQ_DONE = 0;
	localparam int IQ_BTN  = 1;
	localparam int IQ_EJ   = 2;
	// Reset and fixed values
	localparam logic [7:0] STATUS_RST  = 8'h40;
	localparam logic [7:0] STATUS_BUSY = 8'h80;
	localparam logic [7:0] ERROR_RST   = 8'h00;
	localparam logic [7:0] DEVH_RST    = 8'h00;
	localparam logic [3:0] CTRL_RST    = 4'hE;
	localparam logic [2:0] IRQM_RST    = 3'h0;
	localparam logic [31:0] RD_ZERO    = 32'h0000_0000;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_EXEC  = 5'b00010,
		ST_OPS   = 5'b00100,
		ST_SPIN  = 5'b01000,
		ST_EJECT = 5'b10000
	} rmle_state_type;
endpackage : rmle_pkg

// ==== hw/rmle_pin_if.sv ====
// Purpose: Synchronised pin levels passed from the synchroniser to the core
// Assumes: Single clock domain pclk
// Notes: None
`timescale 1ns/1ps
`default_nettype none
interface rmle_pin_if;
	logic present;
	logic button;
	logic fault;
	logic ops_idle;
	logic spun_down;
	modport src (output present, output button, output fault, output ops_idle,
		output spun_down);
	modport dst (input present, input button, input fault, input ops_idle,
		input spun_down);
endinterface : rmle_pin_if
`default_nettype wire

// ==== hw/rmle_sync.sv ====
// Purpose: Two-stage synchroniser for the media pins
// Assumes: Pins are asynchronous to pclk
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module rmle_sync
	import rmle_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [4:0] raw,
	rmle_pin_if.src         pins
);
	typedef struct packed {
		logic [4:0] s1;
		logic [4:0] s2;
	} rmle_sync_type;

	rmle_sync_type r;
	rmle_sync_type n;

	always_comb begin
		n    = r;
		n.s1 = raw;
		n.s2 = r.s1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign pins.present   = r.s2[0];
	assign pins.button    = r.s2[1];
	assign pins.fault     = r.s2[2];
	assign pins.ops_idle  = r.s2[3];
	assign pins.spun_down = r.s2[4];
endmodule : rmle_sync
`default_nettype wire

// ==== sim/rmle_drive_model.sv ====
// Purpose: Drive mechanism model at the media pins of the lock block
// Assumes: Spindle stops four cycles after the spin-down request
// Notes: Medium leaves on the eject pulse and returns on insert
`timescale 1ns/1ps
`default_nettype none
module rmle_drive_model (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic spin_down_req,
	input  wire logic eject_req,
	input  wire logic insert,
	output logic      spun_down,
	output logic      present
);
	logic [1:0] cnt_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 2'h0;
			spun_down <= 1'b0;
			present <= 1'b1;
		end else begin
			if (!spin_down_req)
				cnt_r <= 2'h0;
			else if (cnt_r != 2'h3)
				cnt_r <= cnt_r + 2'h1;
			spun_down <= spin_down_req && (cnt_r == 2'h3);
			if (eject_req)
				present <= 1'b0;
			else if (insert)
				present <= 1'b1;
		end
	end
endmodule : rmle_drive_model
`default_nettype wire

// ==== sim/tb.sv ====
// Purpose: Self-checking bench for the media lock and eject block
// Assumes: APB master tasks, 40 MHz pclk
// Notes: Answers are sampled at the rising edge that completes the access
`timescale 1ns/1ps
`default_nettype none
module tb;
	import rmle_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, q;
	logic        pready, pslverr, perr, spun, present, sdreq, ejreq, irq;
	logic        btn = 0, fault = 0, idle = 1, insert = 0;
	int          fail_count = 0, comparisons = 0, ej_n = 0, n;
	always #12.5 pclk = ~pclk;
	rmle_top i_rmle_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .media_present_pin(present), .change_button_pin(btn),
		.dev_fault_pin(fault), .ops_idle_pin(idle), .spun_down_pin(spun),
		.spin_down_req(sdreq), .eject_req(ejreq), .irq(irq));
	rmle_drive_model i_rmle_drive_model (.pclk(pclk), .presetn(presetn),
		.spin_down_req(sdreq), .eject_req(ejreq), .insert(insert), .spun_down(spun),
		.present(present));
	always @(negedge pclk) if (ejreq === 1'b1) ej_n++;
	task report_and_stop;
		if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	task chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) fail_count++;
		q = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(a, 1'b0, 32'h0000_0000);
		chk(q, e);
	endtask : rd
	task poll;
		n = 0;
		do begin
			apb(OFS_STAT, 1'b0, 32'h0000_0000);
			n++;
		end while (q[ST_BSY] !== 1'b0 && n < 40);
		if (q[ST_BSY] !== 1'b0) fail_count++;
	endtask : poll
	task cmd(input logic [7:0] op);
		apb(OFS_CMD, 1'b1, {24'h00_0000, op});
		poll;
	endtask : cmd
	initial begin
		#200_000;
		fail_count++;
		report_and_stop;
	end
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFS_STAT, 32'h0000_0040);
		rd(OFS_ERR, 32'h0000_0000);
		rd(OFS_CTRL, 32'h0000_000E);
		apb(OFS_DEVH, 1'b1, 32'h0000_0010);
		apb(OFS_IRQM, 1'b1, 32'h0000_0007);
		cmd(OP_LOCK);
		chk(q, 32'h0000_0040);
		rd(OFS_MEDIA, 32'h0000_0003);
		chk({31'h0, irq}, 32'h0000_0001);
		rd(OFS_IRQS, 32'h0000_0001);
		repeat (2) @(negedge pclk);
		chk({31'h0, irq}, 32'h0000_0000);
		cmd(OP_LOCK);
		chk(q, 32'h0000_0040);
		btn <= 1'b1;
		repeat (6) @(posedge pclk);
		btn <= 1'b0;
		repeat (6) @(posedge pclk);
		rd(OFS_STAT, 32'h0000_0041);
		rd(OFS_ERR, 32'h0000_0008);
		rd(OFS_IRQS, 32'h0000_0003);
		cmd(OP_LOCK);
		chk(q, 32'h0000_0041);
		rd(OFS_ERR, 32'h0000_0008);
		cmd(OP_UNLOCK);
		chk(q, 32'h0000_0040);
		repeat (6) @(posedge pclk);
		chk(32'(ej_n), 32'h0000_0001);
		rd(OFS_MEDIA, 32'h0000_0000);
		cmd(OP_LOCK);
		chk(q, 32'h0000_0041);
		rd(OFS_ERR, 32'h0000_0002);
		insert <= 1'b1;
		fault <= 1'b1;
		apb(OFS_CTRL, 1'b1, 32'h0000_000A);
		insert <= 1'b0;
		cmd(OP_LOCK);
		chk(q, 32'h0000_0061);
		rd(OFS_ERR, 32'h0000_0004);
		cmd(8'h00);
		chk(q, 32'h0000_0061);
		fault <= 1'b0;
		apb(OFS_CTRL, 1'b1, 32'h0000_000F);
		cmd(OP_LOCK);
		chk(q, 32'h0000_0040);
		rd(OFS_MEDIA, 32'h0000_0001);
		apb(OFS_CTRL, 1'b1, 32'h0000_000E);
		cmd(OP_LOCK);
		idle <= 1'b0;
		apb(OFS_CMD, 1'b1, {24'h00_0000, OP_EJECT});
		repeat (10) @(posedge pclk);
		chk({31'h0, sdreq}, 32'h0000_0000);
		rd(OFS_STAT, 32'h0000_0080);
		idle <= 1'b1;
		repeat (5) @(posedge pclk);
		chk({31'h0, sdreq}, 32'h0000_0001);
		poll;
		chk(q, 32'h0000_0040);
		repeat (6) @(posedge pclk);
		chk(32'(ej_n), 32'h0000_0002);
		rd(OFS_IRQS, 32'h0000_0005);
		rd(OFS_MEDIA, 32'h0000_0000);
		rd(OFS_DEVH, 32'h0000_0010);
		apb(8'h20, 1'b0, 32'h0000_0000);
		chk({31'h0, perr}, 32'h0000_0001);
		report_and_stop;
	end
endmodule : tb
`default_nettype wire
